// ===== rtl/srqe_pkg.sv
package srqe_pkg;
  // ----------------------------------------
  // Register byte offsets (APB)
  // ----------------------------------------
  localparam logic [7:0] REG_QPFN = 8'h00;  // Queue page frame number
  localparam logic [7:0] REG_QSIZE = 8'h04;  // Queue depth, read only
  localparam logic [7:0] REG_KICK = 8'h08;  // Queue kick field
  localparam logic [7:0] REG_CTRL = 8'h0c;  // Feature and mode bits
  localparam logic [7:0] REG_VEC = 8'h10;  // Queue and config vectors
  localparam logic [7:0] REG_CAUSE = 8'h14;  // Interrupt cause, read clears
  localparam logic [7:0] REG_STAT = 8'h18;  // Ring indices
  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int CTRL_EVIDX = 0;  // Event-index feature negotiated
  localparam int CTRL_MSIX = 1;  // Message interrupts enabled
  localparam int CAUSE_W = 2;  // Cause width
  localparam int CAUSE_QUEUE = 0;  // Queue used bit
  localparam int CAUSE_CFG = 1;  // Config change bit
  localparam int DFLAG_NEXT = 0;  // Descriptor chain flag
  localparam int DFLAG_WRITE = 1;  // Descriptor write-only flag
  localparam int AFLAG_NOINT = 0;  // Driver needs no interrupt
  localparam logic [15:0] NO_VECTOR = 16'hffff;  // No message vector
  localparam logic [15:0] KICK_QUEUE = 16'h0000;  // Our queue index
  // ----------------------------------------
  // Ring layout in guest memory
  // ----------------------------------------
  localparam int PAGE_SHIFT = 12;  // Queue address unit
  localparam logic [63:0] PAGE_MASK = 64'h0000_0000_0000_0fff;
  localparam logic [63:0] DESC_BYTES = 64'h10;  // 16 bytes each
  localparam logic [63:0] DESC_LEN_OFS = 64'h8;  // Length word
  localparam logic [63:0] DESC_FLG_OFS = 64'hc;  // Flags and next word
  localparam logic [63:0] RING_OFS = 64'h4;  // First ring slot
  localparam logic [63:0] AVAIL_TAIL = 64'h6;  // Header plus event word
  localparam logic [63:0] USED_ELEM = 64'h8;  // Used entry size
  localparam int MAX_DEPTH = 32768;  // Largest queue depth
  // ----------------------------------------
  // Memory master request
  // ----------------------------------------
  typedef struct packed {
    logic req;  // Access pending
    logic we;  // Write when high
    logic [63:0] addr;  // Byte address, word aligned
    logic [31:0] wdata;  // Write data
  } srqe_mem_t;
endpackage

// ===== rtl/srqe_engine.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Depth is power of two, max 32768
// - Indices wrap at 65536; new after update
// - Device writes used entry then used index
// - Without event index, queue interrupt only if driver flag clear
// - Event index threshold gates device interrupt
// - Legacy mode sets cause bit 0, irq
// - Message mode sends queue vector unless none
// - Cause read returns value and clears
// - Legacy config change sets cause bit 1, irq
// - Config change message uses config vector
// - Descriptor is 16 bytes: addr,len,flags,next
// - Used entry holds head id, bytes written
// - Avail flags value 1 means no interrupt
module srqe_engine #(
  parameter int QDEPTH = 256  // Ring depth in entries
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output srqe_pkg::srqe_mem_t mem_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic cfg_change_i,
  output logic irq_o,
  output logic msi_vld_o,
  output logic [15:0] msi_vec_o
);
  // ----------------------------------------
  // Engine states
  // ----------------------------------------
  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,  // Waiting for a kick
    ST_AIDX = 11'h002,  // Read avail producer index
    ST_HEAD = 11'h004,  // Read chain head from avail ring
    ST_DLEN = 11'h008,  // Read descriptor length
    ST_DFLG = 11'h010,  // Read descriptor flags and next
    ST_UID = 11'h020,  // Write used entry id
    ST_ULEN = 11'h040,  // Write used entry length
    ST_UIDX = 11'h080,  // Write used producer index
    ST_AFLG = 11'h100,  // Read avail flags
    ST_UEVT = 11'h200,  // Read interrupt threshold
    ST_NOTE = 11'h400   // Decide and raise interrupt
  } srqe_st_t;

  localparam logic [63:0] QD64 = 64'(QDEPTH);
  localparam logic [15:0] QMASK = 16'(QDEPTH - 1);

  srqe_st_t st_r, st_nxt;  // Engine state
  srqe_pkg::srqe_mem_t mem_r, mem_nxt;  // Memory request
  logic [31:0] pfn_r, pfn_nxt;  // Queue page frame
  logic [1:0] ctrl_r, ctrl_nxt;  // Event index and message enables
  logic [15:0] qvec_r, qvec_nxt;  // Queue vector
  logic [15:0] cvec_r, cvec_nxt;  // Config vector
  logic [srqe_pkg::CAUSE_W-1:0] cause_r, cause_nxt;  // Interrupt cause
  logic kick_r, kick_nxt;  // Kick pending
  logic [15:0] last_avail_r, last_avail_nxt;  // Next avail entry to consume
  logic [15:0] avail_idx_r, avail_idx_nxt;  // Snapshot of producer index
  logic [15:0] used_idx_r, used_idx_nxt;  // Device used producer index
  logic [15:0] head_r, head_nxt;  // Chain head id
  logic [15:0] desc_r, desc_nxt;  // Descriptor being walked
  logic [15:0] hops_r, hops_nxt;  // Descriptors walked in chain
  logic [31:0] dlen_r, dlen_nxt;  // Current descriptor length
  logic [31:0] wlen_r, wlen_nxt;  // Bytes written to chain
  logic [15:0] thr_r, thr_nxt;  // Interrupt threshold
  logic noint_r, noint_nxt;  // Driver suppression flag
  logic cmsi_r, cmsi_nxt;  // Config message pending
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic irq_r, msi_vld_r, msi_vld_nxt;
  logic [15:0] msi_vec_r, msi_vec_nxt;

  // ----------------------------------------
  // Ring addresses
  // ----------------------------------------
  logic [63:0] base, avail_base, used_base, pend;
  logic [63:0] head_addr, evt_addr;
  logic [15:0] half, dist_new, dist_old;
  logic need, acc, rd_cause;
  assign base = {20'h0, pfn_r, 12'h0};
  assign avail_base = base + QD64 * srqe_pkg::DESC_BYTES;
  // Used ring starts on the next page after the avail ring
  assign pend = avail_base + srqe_pkg::AVAIL_TAIL + (QD64 << 1) + srqe_pkg::PAGE_MASK;
  assign used_base = pend & ~srqe_pkg::PAGE_MASK;
  assign head_addr = avail_base + srqe_pkg::RING_OFS + {47'h0, last_avail_r & QMASK, 1'b0};
  assign evt_addr = avail_base + srqe_pkg::RING_OFS + (QD64 << 1);
  // Requests go out word aligned, so the lane comes from the field's own address bit 1
  assign half = (st_r == ST_HEAD ? head_addr[1] : evt_addr[1]) ? mem_rdata_i[31:16]
    : mem_rdata_i[15:0];
  // Threshold crossing, both sides modulo 65536
  assign dist_new = used_idx_r - thr_r - 16'h0001;
  assign dist_old = 16'h0001;  // One entry retired per decision
  assign need = ctrl_r[srqe_pkg::CTRL_EVIDX] ? (dist_new < dist_old) : !noint_r;
  assign acc = psel_i && penable_i && pready_r;
  assign rd_cause = acc && !pwrite_i && (paddr_i == srqe_pkg::REG_CAUSE);

  // ----------------------------------------
  // Register file and interrupt delivery
  // ----------------------------------------
  always_comb begin
    pfn_nxt = pfn_r;
    ctrl_nxt = ctrl_r;
    qvec_nxt = qvec_r;
    cvec_nxt = cvec_r;
    cause_nxt = cause_r;
    kick_nxt = kick_r;
    cmsi_nxt = cmsi_r;
    msi_vld_nxt = 1'b0;
    msi_vec_nxt = msi_vec_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    // One wait state: ready rises in the second access cycle
    pready_nxt = psel_i && penable_i && !pready_r;
    if (psel_i && penable_i && !pready_r) begin
      unique case (paddr_i)
        srqe_pkg::REG_QPFN: prdata_nxt = pfn_r;
        srqe_pkg::REG_QSIZE: prdata_nxt = 32'(QDEPTH);
        srqe_pkg::REG_KICK: prdata_nxt = 32'h0;
        srqe_pkg::REG_CTRL: prdata_nxt = {30'h0, ctrl_r};
        srqe_pkg::REG_VEC: prdata_nxt = {cvec_r, qvec_r};
        srqe_pkg::REG_CAUSE: prdata_nxt = {30'h0, cause_r};
        srqe_pkg::REG_STAT: prdata_nxt = {used_idx_r, last_avail_r};
        default: begin
          prdata_nxt = 32'h0;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (acc && pwrite_i) begin
      unique case (paddr_i)
        srqe_pkg::REG_QPFN: pfn_nxt = pwdata_i;
        srqe_pkg::REG_KICK: kick_nxt = kick_r || (pwdata_i[15:0] == srqe_pkg::KICK_QUEUE);
        srqe_pkg::REG_CTRL: ctrl_nxt = pwdata_i[1:0];
        srqe_pkg::REG_VEC: begin
          qvec_nxt = pwdata_i[15:0];
          cvec_nxt = pwdata_i[31:16];
        end
        default: ;
      endcase
    end
    // Clear only what the read returned: a bit set under the read must survive
    if (rd_cause) cause_nxt = cause_r & ~prdata_r[srqe_pkg::CAUSE_W-1:0];
    if (st_r == ST_IDLE && kick_r) kick_nxt = 1'b0;
    // Event sets below win over the read clear above
    if (st_r == ST_NOTE && need) begin
      if (!ctrl_r[srqe_pkg::CTRL_MSIX]) begin
        cause_nxt[srqe_pkg::CAUSE_QUEUE] = 1'b1;
      end else if (qvec_r != srqe_pkg::NO_VECTOR) begin
        msi_vld_nxt = 1'b1;
        msi_vec_nxt = qvec_r;
      end
    end
    if (cfg_change_i) begin
      if (!ctrl_r[srqe_pkg::CTRL_MSIX]) begin
        cause_nxt[srqe_pkg::CAUSE_CFG] = 1'b1;
      end else if (cvec_r != srqe_pkg::NO_VECTOR) begin
        cmsi_nxt = 1'b1;
      end
    end
    // Config message waits for a slot the queue message does not use
    if (cmsi_r && !msi_vld_nxt) begin
      msi_vld_nxt = 1'b1;
      msi_vec_nxt = cvec_r;
      cmsi_nxt = cfg_change_i && ctrl_r[srqe_pkg::CTRL_MSIX];
    end
  end

  // ----------------------------------------
  // Ring engine
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    mem_nxt = mem_r;
    last_avail_nxt = last_avail_r;
    avail_idx_nxt = avail_idx_r;
    used_idx_nxt = used_idx_r;
    head_nxt = head_r;
    desc_nxt = desc_r;
    hops_nxt = hops_r;
    dlen_nxt = dlen_r;
    wlen_nxt = wlen_r;
    thr_nxt = thr_r;
    noint_nxt = noint_r;
    // A request is raised once per memory state and dropped on ack
    if (!mem_r.req && st_r != ST_IDLE && st_r != ST_NOTE) mem_nxt.req = 1'b1;
    if (mem_ack_i) mem_nxt.req = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        mem_nxt.we = 1'b0;
        mem_nxt.addr = avail_base;
        if (kick_r) st_nxt = ST_AIDX;
      end
      ST_AIDX: if (mem_ack_i) begin
        avail_idx_nxt = mem_rdata_i[31:16];
        mem_nxt.addr = head_addr & ~64'h3;
        // Entries exist only once the producer index moved
        st_nxt = (mem_rdata_i[31:16] != last_avail_r) ? ST_HEAD : ST_IDLE;
      end
      ST_HEAD: if (mem_ack_i) begin
        head_nxt = half;
        desc_nxt = half;
        hops_nxt = 16'h0;
        wlen_nxt = 32'h0;
        mem_nxt.addr = base + {44'h0, half & QMASK, 4'h0} + srqe_pkg::DESC_LEN_OFS;
        st_nxt = ST_DLEN;
      end
      ST_DLEN: if (mem_ack_i) begin
        dlen_nxt = mem_rdata_i;
        mem_nxt.addr = base + {44'h0, desc_r & QMASK, 4'h0} + srqe_pkg::DESC_FLG_OFS;
        st_nxt = ST_DFLG;
      end
      ST_DFLG: if (mem_ack_i) begin
        if (mem_rdata_i[srqe_pkg::DFLAG_WRITE]) wlen_nxt = wlen_r + dlen_r;
        hops_nxt = hops_r + 16'h1;
        desc_nxt = mem_rdata_i[31:16];
        // Hop limit stops a looping chain from hanging the engine
        if (mem_rdata_i[srqe_pkg::DFLAG_NEXT] && hops_r != QMASK) begin
          mem_nxt.addr = base + {44'h0, mem_rdata_i[31:16] & QMASK, 4'h0}
            + srqe_pkg::DESC_LEN_OFS;
          st_nxt = ST_DLEN;
        end else begin
          mem_nxt.we = 1'b1;
          mem_nxt.addr = used_base + srqe_pkg::RING_OFS
            + {45'h0, used_idx_r & QMASK, 3'h0};
          mem_nxt.wdata = {16'h0, head_r};
          st_nxt = ST_UID;
        end
      end
      ST_UID: if (mem_ack_i) begin
        mem_nxt.addr = mem_r.addr + 64'h4;
        mem_nxt.wdata = wlen_r;
        st_nxt = ST_ULEN;
      end
      ST_ULEN: if (mem_ack_i) begin
        // Used flags stay zero: kicks are never suppressed
        mem_nxt.addr = used_base;
        mem_nxt.wdata = {used_idx_r + 16'h1, 16'h0};
        st_nxt = ST_UIDX;
      end
      ST_UIDX: if (mem_ack_i) begin
        used_idx_nxt = used_idx_r + 16'h1;
        last_avail_nxt = last_avail_r + 16'h1;
        mem_nxt.we = 1'b0;
        mem_nxt.addr = avail_base;
        st_nxt = ST_AFLG;
      end
      ST_AFLG: if (mem_ack_i) begin
        noint_nxt = mem_rdata_i[srqe_pkg::AFLAG_NOINT];
        mem_nxt.addr = evt_addr & ~64'h3;
        st_nxt = ctrl_r[srqe_pkg::CTRL_EVIDX] ? ST_UEVT : ST_NOTE;
      end
      ST_UEVT: if (mem_ack_i) begin
        thr_nxt = half;
        st_nxt = ST_NOTE;
      end
      ST_NOTE: begin
        // Consume all visible entries before idling
        mem_nxt.addr = head_addr & ~64'h3;
        st_nxt = (last_avail_r != avail_idx_r) ? ST_HEAD : ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_r <= ST_IDLE;
      mem_r <= '0;
      pfn_r <= 32'h0;
      ctrl_r <= 2'h0;
      qvec_r <= srqe_pkg::NO_VECTOR;
      cvec_r <= srqe_pkg::NO_VECTOR;
      cause_r <= '0;
      kick_r <= 1'b0;
      cmsi_r <= 1'b0;
      last_avail_r <= 16'h0;
      avail_idx_r <= 16'h0;
      used_idx_r <= 16'h0;
      head_r <= 16'h0;
      desc_r <= 16'h0;
      hops_r <= 16'h0;
      dlen_r <= 32'h0;
      wlen_r <= 32'h0;
      thr_r <= 16'h0;
      noint_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      msi_vld_r <= 1'b0;
      msi_vec_r <= srqe_pkg::NO_VECTOR;
    end else begin
      st_r <= st_nxt;
      mem_r <= mem_nxt;
      pfn_r <= pfn_nxt;
      ctrl_r <= ctrl_nxt;
      qvec_r <= qvec_nxt;
      cvec_r <= cvec_nxt;
      cause_r <= cause_nxt;
      kick_r <= kick_nxt;
      cmsi_r <= cmsi_nxt;
      last_avail_r <= last_avail_nxt;
      avail_idx_r <= avail_idx_nxt;
      used_idx_r <= used_idx_nxt;
      head_r <= head_nxt;
      desc_r <= desc_nxt;
      hops_r <= hops_nxt;
      dlen_r <= dlen_nxt;
      wlen_r <= wlen_nxt;
      thr_r <= thr_nxt;
      noint_r <= noint_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= (cause_nxt != '0);
      msi_vld_r <= msi_vld_nxt;
      msi_vec_r <= msi_vec_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign mem_o = mem_r;
  assign irq_o = irq_r;
  assign msi_vld_o = msi_vld_r;
  assign msi_vec_o = msi_vec_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_depth;
    @(posedge core_clk_i) disable iff (reset_i)
      (QDEPTH <= srqe_pkg::MAX_DEPTH) && ((QDEPTH & (QDEPTH - 1)) == 0);
  endproperty
  a_depth: assert property (p_depth) else $error("bad depth");
  property p_new;
    @(posedge core_clk_i) disable iff (reset_i)
      (st_r == ST_HEAD) |-> (avail_idx_r != last_avail_r);
  endproperty
  a_new: assert property (p_new) else $error("head read without entry");
  property p_uidx;
    @(posedge core_clk_i) disable iff (reset_i)
      (st_r == ST_UIDX && mem_ack_i) |=> used_idx_r == $past(used_idx_r) + 16'h1;
  endproperty
  a_uidx: assert property (p_uidx) else $error("used index not advanced");
  property p_order;
    @(posedge core_clk_i) disable iff (reset_i)
      $changed(used_idx_r) |-> $past(st_r) == ST_UIDX;
  endproperty
  a_order: assert property (p_order) else $error("used index out of order");
  property p_legacy;
    @(posedge core_clk_i) disable iff (reset_i)
      (st_r == ST_NOTE && need && !ctrl_r[srqe_pkg::CTRL_MSIX])
        |=> cause_r[srqe_pkg::CAUSE_QUEUE] && irq_o;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy irq missing");
  property p_quiet;
    @(posedge core_clk_i) disable iff (reset_i)
      (st_r == ST_NOTE && !need) |=> !msi_vld_o || msi_vec_o == cvec_r;
  endproperty
  a_quiet: assert property (p_quiet) else $error("message without need");
  property p_novec;
    @(posedge core_clk_i) disable iff (reset_i)
      msi_vld_o |-> (msi_vec_o != srqe_pkg::NO_VECTOR) && ctrl_r[srqe_pkg::CTRL_MSIX];
  endproperty
  a_novec: assert property (p_novec) else $error("message to no vector");
  property p_clear;
    @(posedge core_clk_i) disable iff (reset_i)
      (rd_cause && st_r != ST_NOTE && !cfg_change_i)
        |=> ((cause_r & prdata_r[srqe_pkg::CAUSE_W-1:0]) == '0) && (irq_o == (cause_r != '0));
  endproperty
  a_clear: assert property (p_clear) else $error("cause not cleared");
  property p_cfg;
    @(posedge core_clk_i) disable iff (reset_i)
      (cfg_change_i && !ctrl_r[srqe_pkg::CTRL_MSIX]) |=> cause_r[1];
  endproperty
  a_cfg: assert property (p_cfg) else $error("config cause missing");
endmodule

// ===== dv/srqe_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Guest memory holding the rings
// ----------------------------------------
module srqe_mem_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire srqe_pkg::srqe_mem_t mem_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [31:0] store [logic [61:0]];  // Sparse word storage
  int wait_r;  // Cycles left before the next ack
  // Word lookup; unwritten words read zero
  function automatic logic [31:0] rd(input logic [63:0] a);
    return store.exists(a[63:2]) ? store[a[63:2]] : 32'h0;
  endfunction
  // Word write from the driver side
  task automatic wr(input logic [63:0] a, input logic [31:0] d);
    store[a[63:2]] = d;
  endtask
  // Halfword write, lane picked by address bit 1
  task automatic wr16(input logic [63:0] a, input logic [15:0] d);
    logic [31:0] w;
    w = rd(a);
    if (a[1]) begin
      w[31:16] = d;
    end else begin
      w[15:0] = d;
    end
    store[a[63:2]] = w;
  endtask
  // One request at a time, random latency; idle data toggles so stale data never looks valid
  always @(posedge core_clk_i) begin
    if (reset_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h5a5a_a5a5;
      wait_r <= 0;
    end else if (mem_ack_o || !mem_i.req) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (wait_r > 0) begin
      wait_r <= wait_r - 1;
      mem_rdata_o <= ~mem_rdata_o;
    end else begin
      mem_ack_o <= 1'b1;
      wait_r <= $urandom_range(0, 5);
      mem_rdata_o <= rd(mem_i.addr);
      if (mem_i.we) begin
        store[mem_i.addr[63:2]] = mem_i.wdata;
      end
    end
  end
endmodule

// ===== dv/split_ring_queue_engine_tb.sv
`timescale 1ns/10ps
module split_ring_queue_engine_tb;
  // ----------------------------------------
  // Ring layout for page frame 1
  // ----------------------------------------
  localparam int QD = 8;  // Small ring keeps the run short
  localparam logic [63:0] DESC = 64'h1000;
  localparam logic [63:0] AVAIL = 64'h1080;  // After eight descriptors
  localparam logic [63:0] UEVT = 64'h1094;  // Interrupt threshold word
  localparam logic [63:0] USED = 64'h2000;  // Next page boundary
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cfg_chg = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, mrdata, elen;
  logic pready, pslverr, ack, irq, msi_vld, irq_seen = 1'b0, ev, ms, fl;
  logic [15:0] msi_vec, msi_last, aidx = 16'h0, head, qv, thr;
  srqe_pkg::srqe_mem_t mreq;
  int num_errors = 0, checks_done = 0, msi_n = 0;
  always #4 clk = ~clk;
  srqe_engine #(.QDEPTH(QD)) dut (.core_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mem_o(mreq),
    .mem_ack_i(ack), .mem_rdata_i(mrdata), .cfg_change_i(cfg_chg), .irq_o(irq),
    .msi_vld_o(msi_vld), .msi_vec_o(msi_vec));
  srqe_mem_model mem (.core_clk_i(clk), .reset_i(rst), .mem_i(mreq), .mem_ack_o(ack),
    .mem_rdata_o(mrdata));
  // Event monitor: pulses are counted in the cycle they stand
  always @(posedge clk) begin
    if (msi_vld === 1'b1) begin
      msi_n++;
      msi_last = msi_vec;
    end
    if (irq === 1'b1) begin
      irq_seen = 1'b1;
    end
  end
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // APB transfer; holds everything until pready is sampled high
  task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    chk({31'h0, pready}, 32'h1, "pready missing");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chk({31'h0, e}, {31'h0, experr}, "slave error");
  endtask
  // Interrupt decision; the engine decides per entry, so the old index is new minus one
  function automatic logic need_irq(input logic e, input logic f, input logic [15:0] nw,
                                    input logic [15:0] t);
    logic [15:0] gap;
    gap = nw - t - 16'h1;
    return e ? (gap < 16'h1) : !f;
  endfunction
  // Driver side: build a chain, publish it, then kick
  task automatic post(input int n, input int nrd, input logic f, input logic [15:0] t);
    logic [31:0] len;
    logic [15:0] d;
    head = 16'((aidx * 2) % QD);
    elen = 32'h0;
    for (int i = 0; i < n; i++) begin
      len = $urandom_range(1, 300);
      // Chains wrap inside the table so they never spill into the avail ring
      d = 16'((head + i) % QD);
      mem.wr(DESC + 16 * d, $urandom);
      mem.wr(DESC + 16 * d + 8, len);
      mem.wr(DESC + 16 * d + 12, {16'((head + i + 1) % QD), 14'h0, i >= nrd, i < n - 1});
      if (i >= nrd) begin
        elen += len;
      end
    end
    mem.wr16(AVAIL + 4 + 2 * (aidx % QD), head);
    mem.wr16(AVAIL, {15'h0, f});
    mem.wr16(UEVT, t);
    aidx++;
    mem.wr16(AVAIL + 2, aidx);
    wreg(srqe_pkg::REG_KICK, {16'h0, srqe_pkg::KICK_QUEUE});
  endtask
  // Bounded waits for the used index and for an interrupt event
  task automatic settle;
    logic [31:0] w;
    w = mem.rd(USED);
    for (int n = 0; n < 600 && w[31:16] !== aidx; n++) begin
      @(posedge clk);
      w = mem.rd(USED);
    end
    chk(w[31:16], aidx, "used index");
    for (int n = 0; n < 100 && msi_n == 0 && !irq_seen; n++) begin
      @(posedge clk);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog: far beyond the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'ha7b42f74));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(srqe_pkg::REG_QSIZE, QD, 1'b0);
    wreg(srqe_pkg::REG_QSIZE, 32'h0);
    rchk(srqe_pkg::REG_QSIZE, QD, 1'b0);
    rchk(srqe_pkg::REG_VEC, 32'hffff_ffff, 1'b0);
    rchk(srqe_pkg::REG_STAT, 32'h0, 1'b0);
    rchk(8'h1c, 32'h0, 1'b1);
    wreg(srqe_pkg::REG_QPFN, 32'h1);
    rchk(srqe_pkg::REG_QPFN, 32'h1, 1'b0);
    $display("test registers done");
    // Random feature mix, flags, thresholds and vectors
    for (int k = 0; k < 16; k++) begin
      ev = 1'($urandom);
      ms = 1'($urandom);
      fl = 1'($urandom);
      qv = ($urandom_range(0, 2) == 0) ? srqe_pkg::NO_VECTOR : 16'($urandom_range(0, 255));
      thr = $urandom_range(0, 1) ? aidx : 16'($urandom);
      wreg(srqe_pkg::REG_CTRL, {30'h0, ms, ev});
      wreg(srqe_pkg::REG_VEC, {16'hffff, qv});
      msi_n = 0;
      irq_seen = 1'b0;
      post($urandom_range(1, 3), $urandom_range(0, 3), fl, thr);
      settle();
      chk(mem.rd(USED + 4 + 8 * ((aidx - 1) % QD)), {16'h0, head}, "used id");
      chk(mem.rd(USED + 8 + 8 * ((aidx - 1) % QD)), elen, "used length");
      chk(msi_n, (ms && need_irq(ev, fl, aidx, thr) && qv !== srqe_pkg::NO_VECTOR), "msi");
      if (msi_n == 1) chk(msi_last, qv, "msi vector");
      chk(irq_seen, !ms && need_irq(ev, fl, aidx, thr), "irq");
      rchk(srqe_pkg::REG_CAUSE, !ms && need_irq(ev, fl, aidx, thr), 1'b0);
      rchk(srqe_pkg::REG_CAUSE, 32'h0, 1'b0);
    end
    rchk(srqe_pkg::REG_STAT, {aidx, aidx}, 1'b0);
    // Gratuitous kick with nothing new must leave both indices alone
    wreg(srqe_pkg::REG_KICK, {16'h0, srqe_pkg::KICK_QUEUE});
    repeat (40) @(posedge clk);
    rchk(srqe_pkg::REG_STAT, {aidx, aidx}, 1'b0);
    $display("test rings done");
    // Configuration change: legacy, message, message without vector
    for (int k = 0; k < 3; k++) begin
      wreg(srqe_pkg::REG_CTRL, {30'h0, k != 0, 1'b0});
      wreg(srqe_pkg::REG_VEC, {(k == 2) ? srqe_pkg::NO_VECTOR : 16'h0007, 16'hffff});
      msi_n = 0;
      irq_seen = 1'b0;
      cfg_chg <= 1'b1;
      @(posedge clk);
      cfg_chg <= 1'b0;
      repeat (10) @(posedge clk);
      chk(msi_n, k == 1, "config msi");
      if (k == 1) chk(msi_last, 32'h7, "config vector");
      chk(irq_seen, k == 0, "config irq");
      rchk(srqe_pkg::REG_CAUSE, (k == 0) ? 32'h2 : 32'h0, 1'b0);
    end
    // Both causes together in legacy mode
    wreg(srqe_pkg::REG_CTRL, 32'h0);
    post(1, 0, 1'b0, 16'h0);
    settle();
    cfg_chg <= 1'b1;
    @(posedge clk);
    cfg_chg <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(srqe_pkg::REG_CAUSE, 32'h3, 1'b0);
    $display("test config done");
    summarize();
  end
endmodule
